// [pkg/sbrg_pkg.sv]
package sbrg_pkg;

  // register map, byte addresses on the plain register port
  localparam logic [7:0] BDC_OFFSET = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h01;

  // field layout of baud_divider_control
  localparam int PS_LSB = 4;
  localparam int PS_W = 2;
  localparam int RS_LSB = 0;
  localparam int RS_W = 3;

  // values after reset
  localparam logic [7:0] BDC_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // fixed divide-by-64 stage
  localparam int FIX_W = 6;
  localparam logic [5:0] FIX_LIMIT = 6'h3f;

  // prescaler stage: terminal counts are divisor minus one
  localparam int PD_W = 4;
  localparam logic [3:0] PD_LIMIT_00 = 4'h0;
  localparam logic [3:0] PD_LIMIT_01 = 4'h2;
  localparam logic [3:0] PD_LIMIT_10 = 4'h3;
  localparam logic [3:0] PD_LIMIT_11 = 4'hc;

  // rate divisor stage: divisor is two to the field value
  localparam int BD_W = 7;
  localparam logic [6:0] BD_ONE = 7'h01;

endpackage : sbrg_pkg

// [design/sbrg_div_stage.sv]
`timescale 1ns/1ps
`default_nettype none

// one synchronous divider stage: counts steps, pulses on the terminal count
module sbrg_div_stage #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic step,
  input wire logic [W-1:0] limit,
  // result
  output logic tick,
  output logic [W-1:0] count
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } sbrg_stage_t;

  sbrg_stage_t st_ff;
  sbrg_stage_t nxt_st;

  // greater-or-equal guards against a count left above a new limit
  assign tick = step && !clear && (st_ff.cnt >= limit);
  assign count = st_ff.cnt;

  always_comb begin
    nxt_st = st_ff;
    if (clear) begin
      nxt_st.cnt = '0;
    end else if (step) begin
      if (st_ff.cnt >= limit) begin
        nxt_st.cnt = '0;
      end else begin
        nxt_st.cnt = st_ff.cnt + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : sbrg_div_stage

`default_nettype wire

// [design/sbrg_top.sv]
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module sbrg_top (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // bit rate enables
  output logic RX_BAUD_TICK,
  output logic TX_BAUD_TICK
);

  typedef struct packed {
    logic [1:0] prescale_sel;
    logic [2:0] rate_sel;
    logic [7:0] rdata;
    logic rx_tick;
    logic tx_tick;
    logic [7:0] tick_cnt;
    logic [16:0] chk_period;
    logic chk_seen;
    logic [3:0] chk_pd_gap;
    logic chk_pd_seen;
    logic [7:0] chk_mid;
  } sbrg_state_t;

  sbrg_state_t st_ff;
  sbrg_state_t nxt_st;

  logic bdc_wr;
  logic [3:0] pd_limit;
  logic [6:0] bd_limit;
  logic pre_tick;
  logic fix_tick;
  logic rate_tick;

  assign bdc_wr = REG_WR && (REG_ADDR == sbrg_pkg::BDC_OFFSET);

  // prescaler terminal count from the select field
  always_comb begin
    case (st_ff.prescale_sel)
      2'b00: begin
        pd_limit = sbrg_pkg::PD_LIMIT_00;
      end
      2'b01: begin
        pd_limit = sbrg_pkg::PD_LIMIT_01;
      end
      2'b10: begin
        pd_limit = sbrg_pkg::PD_LIMIT_10;
      end
      default: begin
        pd_limit = sbrg_pkg::PD_LIMIT_11;
      end
    endcase
  end

  // power-of-two rate divisor, terminal count is divisor minus one
  assign bd_limit = (sbrg_pkg::BD_ONE << st_ff.rate_sel) - sbrg_pkg::BD_ONE;

  // chain: prescaler, then fixed 64, then rate divisor; a divider register write restarts it
  sbrg_div_stage #(
    .W(sbrg_pkg::PD_W)
  ) u_pre (
    .clk(CORE_CLK),
    .rst(RST),
    .clear(bdc_wr),
    .step(1'b1),
    .limit(pd_limit),
    .tick(pre_tick),
    .count()
  );

  sbrg_div_stage #(
    .W(sbrg_pkg::FIX_W)
  ) u_fix (
    .clk(CORE_CLK),
    .rst(RST),
    .clear(bdc_wr),
    .step(pre_tick),
    .limit(sbrg_pkg::FIX_LIMIT),
    .tick(fix_tick),
    .count()
  );

  sbrg_div_stage #(
    .W(sbrg_pkg::BD_W)
  ) u_rate (
    .clk(CORE_CLK),
    .rst(RST),
    .clear(bdc_wr),
    .step(fix_tick),
    .limit(bd_limit),
    .tick(rate_tick),
    .count()
  );

  always_comb begin
    nxt_st = st_ff;

    // divider register
    if (bdc_wr) begin
      nxt_st.prescale_sel = REG_WDATA[sbrg_pkg::PS_LSB +: sbrg_pkg::PS_W];
      nxt_st.rate_sel = REG_WDATA[sbrg_pkg::RS_LSB +: sbrg_pkg::RS_W];
    end

    // read data stands only in the cycle after the strobe
    nxt_st.rdata = 8'h00;
    if (REG_RD) begin
      if (REG_ADDR == sbrg_pkg::BDC_OFFSET) begin
        nxt_st.rdata = {2'b00, st_ff.prescale_sel, 1'b0, st_ff.rate_sel};
      end else if (REG_ADDR == sbrg_pkg::STAT_OFFSET) begin
        nxt_st.rdata = st_ff.tick_cnt;
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end

    // same pulse to both directions
    nxt_st.rx_tick = rate_tick;
    nxt_st.tx_tick = rate_tick;

    // running count of bit periods, visible in the status register
    if (rate_tick) begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 8'h01;
    end

    // bookkeeping watched by the checks below
    if (bdc_wr) begin
      nxt_st.chk_period = 17'h00000;
      nxt_st.chk_seen = 1'b0;
      nxt_st.chk_pd_gap = 4'h0;
      nxt_st.chk_pd_seen = 1'b0;
      nxt_st.chk_mid = 8'h00;
    end else begin
      if (rate_tick) begin
        nxt_st.chk_period = 17'h00001;
        nxt_st.chk_seen = 1'b1;
        nxt_st.chk_mid = 8'h00;
      end else begin
        nxt_st.chk_period = st_ff.chk_period + 17'h00001;
        if (fix_tick) begin
          nxt_st.chk_mid = st_ff.chk_mid + 8'h01;
        end
      end
      if (pre_tick) begin
        nxt_st.chk_pd_gap = 4'h1;
        nxt_st.chk_pd_seen = 1'b1;
      end else begin
        nxt_st.chk_pd_gap = st_ff.chk_pd_gap + 4'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign REG_RDATA = st_ff.rdata;
  assign RX_BAUD_TICK = st_ff.rx_tick;
  assign TX_BAUD_TICK = st_ff.tx_tick;

  // checks

  chk_same_rate: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    RX_BAUD_TICK == TX_BAUD_TICK
  ) else $error("receiver and transmitter rate enables differ");

  chk_prescale_gap: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (pre_tick && st_ff.chk_pd_seen) |->
      (st_ff.chk_pd_gap ==
        ((st_ff.prescale_sel == 2'b00) ? 4'd1 :
         (st_ff.prescale_sel == 2'b01) ? 4'd3 :
         (st_ff.prescale_sel == 2'b10) ? 4'd4 : 4'd13))
  ) else $error("prescaler period does not match its select code");

  chk_rate_steps: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (rate_tick && st_ff.chk_seen) |->
      ((st_ff.chk_mid + 8'd1) == (8'd1 << st_ff.rate_sel))
  ) else $error("rate divisor does not match its select code");

  chk_bit_period: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (rate_tick && st_ff.chk_seen) |->
      (st_ff.chk_period == 17'd64 *
        ((st_ff.prescale_sel == 2'b00) ? 17'd1 :
         (st_ff.prescale_sel == 2'b01) ? 17'd3 :
         (st_ff.prescale_sel == 2'b10) ? 17'd4 : 17'd13) *
        (17'd1 << st_ff.rate_sel))
  ) else $error("bit period differs from 64 times both divisors");

  chk_reset_fields: assert property (
    @(posedge CORE_CLK)
    $past(RST) |-> (st_ff.prescale_sel == 2'b00 && st_ff.rate_sel == 3'b000)
  ) else $error("divider fields not cleared by reset");

  chk_single_pulse: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    RX_BAUD_TICK |=> !RX_BAUD_TICK [*8]
  ) else $error("rate enable longer than one cycle or too close");

  chk_read_back: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (REG_RD && REG_ADDR == sbrg_pkg::BDC_OFFSET) |=>
      (REG_RDATA == {2'b00, $past(st_ff.prescale_sel), 1'b0, $past(st_ff.rate_sel)})
  ) else $error("divider register read back wrong");

  chk_restart: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    bdc_wr |=> !RX_BAUD_TICK [*8]
  ) else $error("rate enable too soon after a divider write");

  // register port: fields follow a write and hold otherwise
  chk_write_prescale: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    bdc_wr |=>
      (st_ff.prescale_sel == $past(REG_WDATA[sbrg_pkg::PS_LSB +: sbrg_pkg::PS_W]))
  ) else $error("prescale select not taken from a divider write");

  chk_write_rate: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    bdc_wr |=>
      (st_ff.rate_sel == $past(REG_WDATA[sbrg_pkg::RS_LSB +: sbrg_pkg::RS_W]))
  ) else $error("rate select not taken from a divider write");

  chk_fields_hold: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !bdc_wr |=> ($stable(st_ff.prescale_sel) && $stable(st_ff.rate_sel))
  ) else $error("divider fields changed without a write");

  // read data stands for one cycle only and is zero otherwise
  chk_rdata_idle: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !REG_RD |=> (REG_RDATA == 8'h00)
  ) else $error("read data present without a read strobe");

  // outputs are quiet straight after reset
  chk_reset_outputs: assert property (
    @(posedge CORE_CLK)
    $past(RST) |-> (!RX_BAUD_TICK && !TX_BAUD_TICK && REG_RDATA == 8'h00)
  ) else $error("outputs not quiet after reset");

  // the registered enables follow the chain by exactly one cycle
  chk_tick_follows: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    rate_tick |=> RX_BAUD_TICK
  ) else $error("rate enable missing after the chain terminal count");

  chk_no_stray_tick: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !rate_tick |=> !RX_BAUD_TICK
  ) else $error("rate enable without a chain terminal count");

  // each stage can only fire when the stage before it steps
  chk_fix_needs_pre: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    fix_tick |-> pre_tick
  ) else $error("fixed stage fired without a prescaler step");

  chk_rate_needs_fix: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    rate_tick |-> fix_tick
  ) else $error("rate stage fired without a fixed stage step");

  // status counter advances once per bit period
  chk_status_count: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    rate_tick |=> (st_ff.tick_cnt == $past(st_ff.tick_cnt) + 8'h01)
  ) else $error("status count did not advance on a bit period");

  chk_status_hold: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !rate_tick |=> $stable(st_ff.tick_cnt)
  ) else $error("status count moved without a bit period");

endmodule : sbrg_top

`default_nettype wire

// [test/sbrg_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module sbrg_top_bench;
  logic CORE_CLK;
  logic RST;
  logic [7:0] REG_ADDR;
  logic [7:0] REG_WDATA;
  logic REG_WR;
  logic REG_RD;
  logic [7:0] REG_RDATA;
  logic RX_BAUD_TICK;
  logic TX_BAUD_TICK;
  int error_cnt;
  int checks;

  sbrg_top dut (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .RX_BAUD_TICK(RX_BAUD_TICK),
    .TX_BAUD_TICK(TX_BAUD_TICK)
  );

  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic results;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // bit period in clock cycles for a control byte
  function automatic int period(input logic [7:0] d);
    int pd[4] = '{1, 3, 4, 13};
    return 64 * pd[d[5:4]] * (1 << d[2:0]);
  endfunction : period

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1;
    cmp({24'h0, REG_RDATA}, {24'h0, exp});
  endtask : rd

  // counts edges up to the next tick, both enables compared every cycle
  task automatic tick_gap(input int n);
    int c;
    c = 0;
    do begin
      @(posedge CORE_CLK);
      #1;
      c++;
      cmp({31'h0, RX_BAUD_TICK}, {31'h0, TX_BAUD_TICK});
    end while (RX_BAUD_TICK !== 1'b1 && c < n + 4);
    cmp(c, n);
  endtask : tick_gap

  initial begin
    logic [7:0] d;
    RST = 1'b1;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    error_cnt = 0;
    checks = 0;
    void'($urandom(54728));
    repeat (20) @(posedge CORE_CLK);
    RST <= 1'b0;
    tick_gap(64);
    tick_gap(64);
    rd(8'h00, 8'h00);
    rd(8'h07, 8'h00);
    for (int r = 0; r < 8; r++) begin
      d = (8'($urandom) & 8'hc8) | 8'(r);
      wr(8'h00, d);
      tick_gap(period(d));
      rd(8'h00, d & 8'h37);
      tick_gap(period(d) - 2);
    end
    for (int p = 0; p < 4; p++) begin
      d = (8'($urandom) & 8'hc8) | 8'(p << 4) | 8'($urandom_range(2));
      wr(8'h00, d);
      tick_gap(period(d));
      rd(8'h00, d & 8'h37);
      tick_gap(period(d) - 2);
    end
    // same value rewritten mid-period restarts the chain
    repeat (10) @(posedge CORE_CLK);
    wr(8'h00, d);
    tick_gap(period(d));
    wr(8'h01, 8'hff);
    rd(8'h00, d & 8'h37);
    wr(8'h00, 8'h37);
    repeat (5) @(posedge CORE_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    tick_gap(64);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h01);
    results();
  end

  initial begin
    #400000;
    error_cnt++;
    results();
  end
endmodule : sbrg_top_bench

`default_nettype wire
